// [design/hbsc_link.sv]
// serial link side: shifts the control word in and the status word out on the serial clock
`timescale 1ns/1ps
module hbsc_link
  import hbsc_pkg::*;
(
  // serial clock and frame select
  input  wire logic              i_sclk,
  input  wire logic              i_cs_n,
  input  wire logic              i_sdi,
  // status word frozen by the core for this frame
  input  wire logic [WORD_W-1:0] i_snap,
  // serial data out
  output logic                   o_sdo,
  output logic                   o_sdo_oe_n,
  // received frame towards the core
  output logic                   o_rx_full,
  output logic [WORD_W-1:0]      o_rx_word
);

  logic [RXC_W-1:0]  rx_cnt;
  logic [WORD_W-1:0] rx_sr;
  logic [IDX_W-1:0]  tx_idx;

  // bit counter, cleared while the frame is closed; saturates at a full word
  always_ff @(negedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
      rx_cnt <= '0;
    else if (!rx_cnt[RXC_W-1])
      rx_cnt <= rx_cnt + 1'b1;
  end

  // data in sampled on falling clock, first bit ends up in bit 0
  always_ff @(negedge i_sclk)
  begin
    rx_sr <= {i_sdi, rx_sr[WORD_W-1:1]};
  end

  // status index moves only on rising clock, after the first sample
  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
      tx_idx <= '0;
    else if (rx_cnt != '0)
      tx_idx <= tx_idx + 1'b1;
  end

  // pin drive: enabled by the select itself, bit 0 shows at once
  assign o_sdo      = i_snap[tx_idx];
  assign o_sdo_oe_n = i_cs_n;
  assign o_rx_full  = rx_cnt[RXC_W-1];
  assign o_rx_word  = rx_sr;

endmodule

// [design/hbsc_top.sv]
// half-bridge driver serial control and status core
`timescale 1ns/1ps
module hbsc_top
  import hbsc_pkg::*;
#(
  parameter int unsigned SC_LONG_CYC = SC_LONG_CYC_DEF,
  parameter int unsigned SC_SHRT_CYC = SC_SHRT_CYC_DEF
)
(
  // system clock and reset
  input  wire logic           i_mclk,
  input  wire logic           i_rst,
  // serial link pins
  input  wire logic           i_sclk,
  input  wire logic           i_cs_n,
  input  wire logic           i_serial_in_pin,
  output logic                o_sdo,
  output logic                o_sdo_oe_n,
  // standby request pin and analog conditions
  input  wire logic           i_standby_request_pin_n,
  input  wire logic           i_heat_warn,
  input  wire logic           i_overtemp,
  input  wire logic           i_undervolt,
  input  wire logic [NSW-1:0] i_short_det,
  input  wire logic [NSW-1:0] i_open_load,
  // output stage controls
  output logic [NSW-1:0]      o_switch_on,
  output logic                o_open_load_en,
  output logic                o_long_delay
);

  typedef struct packed {
    logic [SY_W-1:0]           s1;
    logic [SY_W-1:0]           s2;
    logic                      cs_d;
    logic                      full_d;
    logic [WORD_W-1:0]         ctrl;
    logic [WORD_W-1:0]         snap;
    logic [NSW-1:0][SC_W-1:0]  sc_cnt;
    logic [NSW-1:0]            sc_off;
    logic                      short_fault_flag;
    logic                      supply_fail_flag;
    logic                      ot;
    logic                      uv_off;
    logic [UV_W-1:0]           uv_cnt;
    logic [NSW-1:0]            sw_on;
    logic                      open_en;
    logic                      long_dly;
  } hbsc_state_t;

  hbsc_state_t       r;
  hbsc_state_t       next_r;
  logic [SY_W-1:0]   raw;
  logic              rx_full;
  logic [WORD_W-1:0] rx_word;
  logic              cs_s;
  logic              full_s;
  logic              inh_n_s;
  logic              heat_s;
  logic              ot_s;
  logic              uv_s;
  logic [NSW-1:0]    short_s;
  logic [NSW-1:0]    open_s;
  logic              cs_fall;
  logic              cs_rise;
  logic              apply;
  logic              clear;
  logic              standby;
  logic [SC_W-1:0]   sc_lim;
  logic [WORD_W-1:0] status_w;

  // serial shifter on the link clock
  hbsc_link hbsc_link_i (
    .i_sclk     (i_sclk),
    .i_cs_n     (i_cs_n),
    .i_sdi      (i_serial_in_pin),
    .i_snap     (r.snap),
    .o_sdo      (o_sdo),
    .o_sdo_oe_n (o_sdo_oe_n),
    .o_rx_full  (rx_full),
    .o_rx_word  (rx_word)
  );

  // everything from outside the clock domain except the received word rx_word enters the synchroniser
  assign raw = {i_open_load, i_short_det, i_undervolt, i_overtemp, i_heat_warn,
                i_standby_request_pin_n, rx_full, i_cs_n};

  // synchronised views, second stage only
  assign cs_s    = r.s2[SY_CS];
  assign full_s  = r.s2[SY_FULL];
  assign inh_n_s = r.s2[SY_INH];
  assign heat_s  = r.s2[SY_HEAT];
  assign ot_s    = r.s2[SY_OT];
  assign uv_s    = r.s2[SY_UV];
  assign short_s = r.s2[SY_SHORT +: NSW];
  assign open_s  = r.s2[SY_OPEN +: NSW];

  // frame edges; word complete is judged from the cycle before the rise
  assign cs_fall = !cs_s && r.cs_d;
  assign cs_rise = cs_s && !r.cs_d;
  assign apply   = cs_rise && r.full_d;
  assign clear   = apply && rx_word[CB_CLEAR];
  assign standby = !r.ctrl[CB_RUN] || !inh_n_s;

  // shutdown delay picked by the control word
  assign sc_lim = r.ctrl[CB_DELAY] ? SC_W'(SC_LONG_CYC - 1)
                                   : SC_W'(SC_SHRT_CYC - 1);

  // status word as the host will see it
  always_comb
  begin
    status_w           = '0;
    status_w[SB_HEAT]  = heat_s;
    status_w[SB_SW +: NSW] = r.open_en ? (open_s & ~r.sw_on) : r.sw_on;
    status_w[SB_SCD]   = r.short_fault_flag;
    status_w[SB_STBY]  = standby;
    status_w[SB_PSF]   = r.supply_fail_flag;
    if (r.ot)
      status_w = '1;
  end

  // next state of the core
  always_comb
  begin
    next_r        = r;
    next_r.s1     = raw;
    next_r.s2     = r.s1;
    next_r.cs_d   = cs_s;
    next_r.full_d = full_s;

    // control word taken only on a complete frame
    if (apply)
      next_r.ctrl = rx_word;

    // status frozen for the frame that just opened
    if (cs_fall)
      next_r.snap = status_w;

    // undervoltage timer; recovery releases outputs at once
    if (uv_s)
    begin
      if (r.uv_cnt != UV_W'(UV_CYC - 1))
        next_r.uv_cnt = r.uv_cnt + 1'b1;
      else
        next_r.uv_off = 1'b1;
    end
    else
    begin
      next_r.uv_cnt = '0;
      next_r.uv_off = 1'b0;
    end

    // supply fail flag, set wins over clear
    if (clear)
      next_r.supply_fail_flag = 1'b0;
    if (uv_s && r.uv_cnt == UV_W'(UV_CYC - 1))
      next_r.supply_fail_flag = 1'b1;

    // overtemperature latch, cleared only once cooled
    if (clear && !ot_s)
      next_r.ot = 1'b0;
    if (ot_s)
      next_r.ot = 1'b1;

    // short flags cleared first so a new shutdown still lands
    if (clear)
    begin
      next_r.short_fault_flag    = 1'b0;
      next_r.sc_off = '0;
    end

    // per switch short timer; a prewarning cuts it short
    for (int i = 0; i < NSW; i++)
    begin
      if (r.sw_on[i] && short_s[i])
      begin
        if (heat_s || r.sc_cnt[i] >= sc_lim)
        begin
          next_r.sc_off[i] = 1'b1;
          next_r.short_fault_flag       = 1'b1;
          next_r.sc_cnt[i] = '0;
        end
        else
          next_r.sc_cnt[i] = r.sc_cnt[i] + 1'b1;
      end
      else
        next_r.sc_cnt[i] = '0;
    end

    // output stage drive
    if (standby || r.uv_off || r.ot)
      next_r.sw_on = '0;
    else
      next_r.sw_on = r.ctrl[CB_SW_HI:CB_SW_LO] & ~r.sc_off;

    next_r.open_en  = !r.ctrl[CB_OPEN];
    next_r.long_dly = r.ctrl[CB_DELAY];
  end

  // state register
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      r            <= '0;
      r.ctrl       <= CTRL_RESET;
      // select and standby pin idle high, so no false select edge follows reset
      r.s1[SY_CS]  <= 1'b1;
      r.s2[SY_CS]  <= 1'b1;
      r.s1[SY_INH] <= 1'b1;
      r.s2[SY_INH] <= 1'b1;
      r.cs_d       <= 1'b1;
    end
    else
      r <= next_r;
  end

  // outputs straight from the state
  assign o_switch_on    = r.sw_on;
  assign o_open_load_en = r.open_en;
  assign o_long_delay   = r.long_dly;

  // checks
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  ctrl_reset_a: assert property ($past(i_rst) |-> r.ctrl == CTRL_RESET)
    else $error("control word not at reset value");

  ctrl_hold_a: assert property (!apply |=> r.ctrl == $past(r.ctrl))
    else $error("control word changed outside a frame end");

  ctrl_load_a: assert property (apply |=> r.ctrl == $past(rx_word))
    else $error("control word not loaded at frame end");

  abort_keep_a: assert property (cs_rise && !r.full_d |=> $stable(r.ctrl) && $stable(r.snap))
    else $error("aborted frame changed a register");

  status_clear_a: assert property (clear && !uv_s && !ot_s && short_s == '0 |=> !r.supply_fail_flag && !r.short_fault_flag && !r.ot)
    else $error("status clear left a flag set");

  switch_map_a: assert property (!standby && !r.uv_off && !r.ot && r.sc_off == '0
                                 |=> r.sw_on == $past(r.ctrl[CB_SW_HI:CB_SW_LO]))
    else $error("switch drive does not follow control bits");

  standby_off_a: assert property (standby |=> r.sw_on == '0)
    else $error("outputs on during standby");

  standby_bit_a: assert property (!r.ot |-> status_w[SB_STBY] == (!r.ctrl[CB_RUN] || !inh_n_s))
    else $error("standby status bit wrong");

  ot_all_high_a: assert property (r.ot |-> status_w == '1 ##1 r.sw_on == '0)
    else $error("overtemperature status not all high");

  uv_delay_a: assert property ($rose(r.uv_off) |-> $past(r.uv_cnt) == UV_W'(UV_CYC - 1) && r.supply_fail_flag)
    else $error("undervoltage shutdown before the full delay");

  uv_recover_a: assert property (r.uv_off && !uv_s |=> !r.uv_off ##1 !r.uv_off || uv_s)
    else $error("outputs not released on supply recovery");

  psf_hold_a: assert property (r.supply_fail_flag && !clear |=> r.supply_fail_flag)
    else $error("supply fail flag dropped without clear");

  snap_capture_a: assert property (cs_fall |=> r.snap == $past(status_w) ##1 $stable(r.snap))
    else $error("status snapshot not taken at select fall");

  frame_apply_c: cover property (apply ##1 r.ctrl[CB_CLEAR]);
  frame_abort_c: cover property (cs_rise && !r.full_d);
  supply_fail_c: cover property ($rose(r.supply_fail_flag));
  short_off_c:   cover property ($rose(r.short_fault_flag));

endmodule

// [include/hbsc_pkg.sv]
// shared constants of the half-bridge serial control block
package hbsc_pkg;

  // clock rate and word geometry
  localparam int CLK_MHZ = 100;
  localparam int WORD_W  = 16;
  localparam int NSW     = 12;
  localparam int IDX_W   = 4;
  localparam int RXC_W   = 5;

  // control word bit positions
  localparam int CB_CLEAR = 0;
  localparam int CB_SW_LO = 1;
  localparam int CB_SW_HI = 12;
  localparam int CB_OPEN  = 13;
  localparam int CB_DELAY = 14;
  localparam int CB_RUN   = 15;

  // status word bit positions
  localparam int SB_HEAT = 0;
  localparam int SB_SW   = 1;
  localparam int SB_SCD  = 13;
  localparam int SB_STBY = 14;
  localparam int SB_PSF  = 15;

  // control word after power-on reset
  localparam logic [WORD_W-1:0] CTRL_RESET = 16'hE000;

  // short-circuit shutdown delays
  localparam real         SC_LONG_MS      = 12.0;
  localparam real         SC_SHORT_MS     = 1.5;
  localparam int unsigned SC_LONG_CYC_DEF = $rtoi(SC_LONG_MS * 1000.0 * CLK_MHZ);
  localparam int unsigned SC_SHRT_CYC_DEF = $rtoi(SC_SHORT_MS * 1000.0 * CLK_MHZ);
  localparam int          SC_W            = 21;

  // supply undervoltage delay
  localparam int UV_DELAY_US = 10;
  localparam int UV_CYC      = UV_DELAY_US * CLK_MHZ;
  localparam int UV_W        = 10;

  // positions in the synchroniser vector
  localparam int SY_CS    = 0;
  localparam int SY_FULL  = 1;
  localparam int SY_INH   = 2;
  localparam int SY_HEAT  = 3;
  localparam int SY_OT    = 4;
  localparam int SY_UV    = 5;
  localparam int SY_SHORT = 6;
  localparam int SY_OPEN  = 18;
  localparam int SY_W     = 30;

endpackage

// [sim/hbsc_host.sv]
// host model: frames control words out and collects status words on the serial link
`timescale 1ns/1ps
module hbsc_host
(
  // serial link pins
  output logic        o_sclk,
  output logic        o_cs_n,
  output logic        o_sdi,
  input  wire logic   i_sdo,
  // status word seen in the last frame, toggle per frame
  output logic [15:0] o_st,
  output logic        o_done
);
  initial
  begin
    o_sclk = 1'b0;
    o_sdi  = 1'b0;
    o_st   = 16'h0000;
    o_done = 1'b0;
    // select rises after time zero so the link counters see a real edge
    #1;
    o_cs_n = 1'b1;
  end

  // one frame of n bits; serial clock runs only inside the frame
  task automatic xfer(input logic [15:0] w, input int n);
    int i;
    #3.7;
    o_st   = 16'h0000;
    o_cs_n = 1'b0; // frame opens
    #60;
    for (i = 0; i < n; i++)
    begin
      o_sclk = 1'b1;
      o_sdi  = w[i]; // lowest bit first
      #15;
      o_st[i] = i_sdo;
      o_sclk  = 1'b0;
      #15;
    end
    o_cs_n = 1'b1; // short frames abort
    o_sdi  = ~o_sdi; // idle data keeps moving
    o_done = ~o_done;
    #100;
  endtask
endmodule

// [sim/hbsc_top_tb_top.sv]
// self-checking bench for the half-bridge serial control core
`timescale 1ns/1ps
module hbsc_top_tb_top;
  import hbsc_pkg::*;
  localparam int LNG = 40;
  localparam int SHT = 10;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_standby_request_pin_n = 1'b1;
  logic i_heat_warn = 1'b0, i_overtemp = 1'b0, i_undervolt = 1'b0;
  logic [NSW-1:0] i_short_det = '0, i_open_load = '0;
  wire sclk, cs_n, sdi, o_sdo, o_sdo_oe_n, done, o_open_load_en, o_long_delay;
  wire [15:0] st;
  wire [NSW-1:0] o_switch_on;
  wire sdo_line = o_sdo_oe_n ? 1'bz : o_sdo;
  int failures = 0, checked = 0, i, d;
  int seed = 32'h0df36e4f;
  logic [15:0] cw = CTRL_RESET, w;
  logic supply_fail_flag = 0, short_fault_flag = 0, ot = 0;
  logic [11:0] shorted = '0;
  logic [15:0] expq [$];

  hbsc_top #(.SC_LONG_CYC(LNG), .SC_SHRT_CYC(SHT)) hbsc_top_i (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_serial_in_pin(sdi), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n),
    .i_standby_request_pin_n(i_standby_request_pin_n), .i_heat_warn(i_heat_warn), .i_overtemp(i_overtemp),
    .i_undervolt(i_undervolt), .i_short_det(i_short_det), .i_open_load(i_open_load),
    .o_switch_on(o_switch_on), .o_open_load_en(o_open_load_en), .o_long_delay(o_long_delay));
  hbsc_host hbsc_host_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo_line), .o_st(st), .o_done(done));

  always #5 i_mclk = ~i_mclk;

  // expected switch drive and status word from the bench's own state
  function automatic logic [11:0] sw_exp();
    return (cw[15] && i_standby_request_pin_n) ? cw[12:1] & ~shorted : 12'h000;
  endfunction
  function automatic logic [15:0] st_exp();
    logic [11:0] s;
    s = sw_exp();
    if (ot)
      return 16'hFFFF;
    return {supply_fail_flag, ~cw[15] | ~i_standby_request_pin_n, short_fault_flag, cw[13] ? s : i_open_load & ~s, i_heat_warn};
  endfunction

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one frame: note the status due, send, then check outputs
  task automatic send(logic [15:0] wd, int n);
    repeat (4) @(posedge i_mclk);
    expq.push_back(st_exp() & (16'hFFFF >> (16 - n)));
    // data out must be driven while the frame is open
    fork
      hbsc_host_i.xfer(wd, n);
      begin
        #25;
        chk("sdo drive", {15'h0, o_sdo_oe_n}, 16'h0000);
      end
    join
    if (n >= 16)
    begin
      cw = wd;
      if (wd[0])
        {supply_fail_flag, short_fault_flag, ot, shorted} = '0;
    end
    repeat (12) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("switches", {4'h0, o_switch_on}, {4'h0, sw_exp()});
    chk("settings", {14'h0, o_open_load_en, o_long_delay}, {14'h0, ~cw[13], cw[14]});
    chk("sdo enable", {15'h0, o_sdo_oe_n}, 16'h0001);
  endtask

  // status watcher pairs each finished frame with the oldest note
  initial
  begin
    @(negedge i_rst);
    forever
    begin
      @(done);
      chk("status", st, expq.pop_front());
    end
  end

  task close_out;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #400000;
    failures++;
    close_out();
  end

  initial
  begin
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    send(CTRL_RESET, 16); // reset word
    $display("test reset done");
    for (i = 0; i < 4; i++)
    begin
      @(posedge i_mclk) i_heat_warn <= i[0];
      send({3'b111, 12'($random(seed)), 1'b0}, 16);
    end
    send(16'h0000, 1); // early abort keeps the control word
    $display("test switches done");
    @(posedge i_mclk) i_open_load <= 12'($random(seed));
    w = {3'b100, 12'($random(seed)), 1'b0};
    send(w, 16);
    send(w, 16); // open-load status
    $display("test open load done");
    @(posedge i_mclk) i_standby_request_pin_n <= 1'b0;
    send(16'hFFFE, 16);
    send(16'hFFFE, 16);
    @(posedge i_mclk) i_standby_request_pin_n <= 1'b1;
    send(16'h7FFE, 16);
    send(16'h7FFE, 16);
    $display("test standby done");
    @(posedge i_mclk) i_heat_warn <= 1'b0;
    for (d = 0; d < 2; d++)
    begin
      w = {1'b1, d[0], 14'h3FFE};
      send(w, 16);
      @(posedge i_mclk) i_short_det <= 12'h001;
      repeat ((d ? LNG : SHT) - 4) @(posedge i_mclk);
      @(negedge i_mclk);
      chk("short wait", {15'h0, o_switch_on[0]}, 16'h0001);
      repeat (12) @(posedge i_mclk);
      @(negedge i_mclk);
      chk("short off", {15'h0, o_switch_on[0]}, 16'h0000);
      {short_fault_flag, shorted} = {1'b1, 12'h001};
      @(posedge i_mclk) i_short_det <= 12'h000;
      send(w | 16'h0001, 16); // clear re-enables
    end
    // a prewarning during a short cuts the long delay short
    @(posedge i_mclk) {i_heat_warn, i_short_det} <= {1'b1, 12'h002};
    repeat (8) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("short hot", {4'h0, o_switch_on}, 16'h0FFD);
    {short_fault_flag, shorted} = {1'b1, 12'h002};
    @(posedge i_mclk) {i_heat_warn, i_short_det} <= 13'h0000;
    send(16'hFFFF, 16);
    $display("test short done");
    send(16'hFFFE, 16);
    @(posedge i_mclk) i_undervolt <= 1'b1;
    repeat (990) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("uv wait", {4'h0, o_switch_on}, 16'h0FFF);
    repeat (20) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("uv off", {4'h0, o_switch_on}, 16'h0000);
    supply_fail_flag = 1'b1;
    @(posedge i_mclk) i_undervolt <= 1'b0;
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("uv back", {4'h0, o_switch_on}, 16'h0FFF);
    send(16'hFFFE, 16);
    send(16'hFFFF, 16);
    send(16'hFFFE, 16);
    $display("test supply done");
    send(16'hE000, 16);
    @(posedge i_mclk) i_overtemp <= 1'b1;
    ot = 1'b1;
    send(16'hE000, 16);
    @(posedge i_mclk) i_overtemp <= 1'b0;
    send(16'hE001, 16);
    send(16'hE000, 16);
    $display("test overtemp done");
    close_out();
  end
endmodule
